// [buck_cfg_params.svh]
// register offsets, field positions, reset values and masks of the
// buck configuration bank; assumes byte-wide registers on an 8-bit map
`ifndef BUCK_CFG_PARAMS_SVH
`define BUCK_CFG_PARAMS_SVH

// ********************************************************************
// register offsets
// ********************************************************************
`define OFS_PAIR_NORMAL 8'h20
`define OFS_PAIR_STANDBY 8'h21
`define OFS_PAIR_SLEEP 8'h22
`define OFS_PAIR_MODE 8'h23
`define OFS_PAIR_CONF 8'h24
`define OFS_THIRD_NORMAL 8'h2E
`define OFS_THIRD_STANDBY 8'h2F
`define OFS_THIRD_SLEEP 8'h30
`define OFS_THIRD_MODE 8'h31
`define OFS_THIRD_CONF 8'h32

// ********************************************************************
// register indices inside the bank
// ********************************************************************
`define NUM_REGS 10
`define IDX_PAIR_NORMAL 0
`define IDX_PAIR_STANDBY 1
`define IDX_PAIR_SLEEP 2
`define IDX_PAIR_MODE 3
`define IDX_PAIR_CONF 4
`define IDX_THIRD_NORMAL 5
`define IDX_THIRD_STANDBY 6
`define IDX_THIRD_SLEEP 7
`define IDX_THIRD_MODE 8
`define IDX_THIRD_CONF 9

// ********************************************************************
// reset values and writable-bit masks
// ********************************************************************
`define RST_CODE 8'h00
`define RST_MODE 8'h08
`define RST_CONF 8'h00
`define MASK_CODE 8'h3F
`define MASK_MODE 8'h2F
`define MASK_CONF 8'hFF
`define RST_MODE_FIELD 4'h8

// ********************************************************************
// field positions
// ********************************************************************
`define CODE_MSB 5
`define MODE_MSB 3
`define SLEEP_STATE_BIT 5
`define ILIM_BIT 0
`define SPARE_BIT 1
`define FREQ_MSB 3
`define FREQ_LSB 2
`define PHASE_MSB 5
`define PHASE_LSB 4
`define RAMP_MSB 7
`define RAMP_LSB 6

// ********************************************************************
// set-point scale in millivolts
// ********************************************************************
`define VBASE_MV 11'd300
`define VSTEP_MV 11'd25

`endif

// [buck_cfg_pkg.sv]
// types shared by the buck configuration bank and its byte registers;
// assumes buck_cfg_params.svh supplies the numeric constants
package buck_cfg_pkg;

    typedef enum logic [1:0] {
        PWR_NORMAL = 2'h0,
        PWR_STANDBY = 2'h1,
        PWR_SLEEP = 2'h2
    } power_state_t;

    typedef struct packed {
        logic [7:0] value;
    } byte_reg_t;

    typedef struct packed {
        logic [7:0] rd_data;
        logic rd_valid;
        logic [5:0] pair_code;
        logic [5:0] third_code;
        logic [10:0] pair_mv;
        logic [10:0] third_mv;
        logic pair_on;
        logic third_on;
        logic pair_pfm;
        logic third_pfm;
    } bank_state_t;

endpackage

// [cfg_byte_reg.sv]
// one byte-wide configuration register with per-bit write mask;
// assumes write strobe and data come from logic on core_clk
`timescale 1ns/1ps
`include "buck_cfg_params.svh"

module cfg_byte_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00,
    parameter logic [7:0] WRITE_MASK = 8'hFF
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // write port
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    // stored value
    output logic [7:0] value
);

    buck_cfg_pkg::byte_reg_t state;
    buck_cfg_pkg::byte_reg_t next_state;

    // masked bits stay at reset value, so they read back as the RESET_VALUE bits (zero in every register of this bank)
    always_comb begin
        next_state = state;
        if (wr_en) begin
            next_state.value = (wdata & WRITE_MASK) |
                               (RESET_VALUE & ~WRITE_MASK);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state.value <= RESET_VALUE;
        end else begin
            state <= next_state;
        end
    end

    assign value = state.value;

endmodule

// [buck_cfg_bank.sv]
// configuration bank of the paired buck and the third buck: voltage
// set-points, switching mode, sleep state, current limit, frequency,
// phase clock and ramp speed; assumes the control serial bus slave
// presents byte accesses on core_clk and the power-mode sequencer
// drives power_state on the same clock
`timescale 1ns/1ps
`include "buck_cfg_params.svh"

module buck_cfg_bank (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // register access from the control bus slave
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rd_data,
    output logic rd_valid,
    // power mode from the sequencer
    input wire buck_cfg_pkg::power_state_t power_state,
    // paired buck settings
    output logic [5:0] pair_normal_code,
    output logic [5:0] pair_standby_code,
    output logic [5:0] pair_sleep_code,
    output logic [3:0] pair_mode_field,
    output logic pair_sleep_state_bit,
    output logic pair_current_limit_bit,
    output logic [1:0] pair_frequency_field,
    output logic [1:0] pair_phase_field,
    output logic [1:0] pair_ramp_speed_field,
    // per-phase copies of the shared pair settings
    output logic [1:0] phase_a_freq,
    output logic [1:0] phase_b_freq,
    output logic [1:0] phase_a_ramp,
    output logic [1:0] phase_b_ramp,
    // paired buck operating point
    output logic [5:0] pair_active_code,
    output logic [10:0] pair_setpoint_mv,
    output logic pair_regulator_on,
    output logic pair_sleep_pfm,
    // third buck settings
    output logic [5:0] third_normal_code,
    output logic [5:0] third_standby_code,
    output logic [5:0] third_sleep_code,
    output logic [3:0] third_mode_field,
    output logic third_sleep_state_bit,
    output logic third_current_limit_bit,
    output logic [1:0] third_frequency_field,
    output logic [1:0] third_phase_field,
    output logic [1:0] third_ramp_speed_field,
    // third buck operating point
    output logic [5:0] third_active_code,
    output logic [10:0] third_setpoint_mv,
    output logic third_regulator_on,
    output logic third_sleep_pfm
);

    // ****************************************************************
    // register map tables
    // ****************************************************************
    localparam logic [7:0] REG_OFS [`NUM_REGS] = '{
        `OFS_PAIR_NORMAL,
        `OFS_PAIR_STANDBY,
        `OFS_PAIR_SLEEP,
        `OFS_PAIR_MODE,
        `OFS_PAIR_CONF,
        `OFS_THIRD_NORMAL,
        `OFS_THIRD_STANDBY,
        `OFS_THIRD_SLEEP,
        `OFS_THIRD_MODE,
        `OFS_THIRD_CONF
    };

    // spare config bit 1 stays writable; mode bit 4 and top bits do not
    localparam logic [7:0] REG_MASK [`NUM_REGS] = '{
        `MASK_CODE, `MASK_CODE, `MASK_CODE, `MASK_MODE, `MASK_CONF,
        `MASK_CODE, `MASK_CODE, `MASK_CODE, `MASK_MODE, `MASK_CONF
    };

    localparam logic [7:0] REG_RST [`NUM_REGS] = '{
        `RST_CODE, `RST_CODE, `RST_CODE, `RST_MODE, `RST_CONF,
        `RST_CODE, `RST_CODE, `RST_CODE, `RST_MODE, `RST_CONF
    };

    // ****************************************************************
    // register storage
    // ****************************************************************
    logic [7:0] reg_value [`NUM_REGS];
    logic [`NUM_REGS-1:0] hit;

    genvar gi;
    generate
        for (gi = 0; gi < `NUM_REGS; gi = gi + 1) begin : g_reg
            assign hit[gi] = (addr == REG_OFS[gi]);
            cfg_byte_reg #(
                .RESET_VALUE(REG_RST[gi]),
                .WRITE_MASK(REG_MASK[gi])
            ) u_reg (
                .core_clk(core_clk),
                .nrst(nrst),
                .wr_en(wr_en && hit[gi]),
                .wdata(wdata),
                .value(reg_value[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // field outputs
    // ****************************************************************
    logic [7:0] pair_mode_reg;
    logic [7:0] pair_conf_reg;
    logic [7:0] third_mode_reg;
    logic [7:0] third_conf_reg;

    assign pair_mode_reg = reg_value[`IDX_PAIR_MODE];
    assign pair_conf_reg = reg_value[`IDX_PAIR_CONF];
    assign third_mode_reg = reg_value[`IDX_THIRD_MODE];
    assign third_conf_reg = reg_value[`IDX_THIRD_CONF];

    assign pair_normal_code =
        reg_value[`IDX_PAIR_NORMAL][`CODE_MSB:0];
    assign pair_standby_code =
        reg_value[`IDX_PAIR_STANDBY][`CODE_MSB:0];
    assign pair_sleep_code =
        reg_value[`IDX_PAIR_SLEEP][`CODE_MSB:0];
    assign pair_mode_field = pair_mode_reg[`MODE_MSB:0];
    assign pair_sleep_state_bit =
        pair_mode_reg[`SLEEP_STATE_BIT];
    assign pair_current_limit_bit = pair_conf_reg[`ILIM_BIT];
    assign pair_frequency_field =
        pair_conf_reg[`FREQ_MSB:`FREQ_LSB];
    assign pair_phase_field =
        pair_conf_reg[`PHASE_MSB:`PHASE_LSB];
    assign pair_ramp_speed_field =
        pair_conf_reg[`RAMP_MSB:`RAMP_LSB];

    // both phases run off one register, so they cannot drift apart
    assign phase_a_freq = pair_frequency_field;
    assign phase_b_freq = pair_frequency_field;
    assign phase_a_ramp = pair_ramp_speed_field;
    assign phase_b_ramp = pair_ramp_speed_field;

    assign third_normal_code =
        reg_value[`IDX_THIRD_NORMAL][`CODE_MSB:0];
    assign third_standby_code =
        reg_value[`IDX_THIRD_STANDBY][`CODE_MSB:0];
    assign third_sleep_code =
        reg_value[`IDX_THIRD_SLEEP][`CODE_MSB:0];
    assign third_mode_field = third_mode_reg[`MODE_MSB:0];
    assign third_sleep_state_bit =
        third_mode_reg[`SLEEP_STATE_BIT];
    assign third_current_limit_bit = third_conf_reg[`ILIM_BIT];
    assign third_frequency_field =
        third_conf_reg[`FREQ_MSB:`FREQ_LSB];
    assign third_phase_field =
        third_conf_reg[`PHASE_MSB:`PHASE_LSB];
    assign third_ramp_speed_field =
        third_conf_reg[`RAMP_MSB:`RAMP_LSB];

    // ****************************************************************
    // read path and operating point
    // ****************************************************************
    function automatic logic [10:0] code_to_mv(input logic [5:0] code);
        code_to_mv = `VBASE_MV + ({5'h00, code} * `VSTEP_MV);
    endfunction

    function automatic logic [5:0] pick_code(
        input buck_cfg_pkg::power_state_t ps,
        input logic [5:0] normal_code,
        input logic [5:0] standby_code,
        input logic [5:0] sleep_code
    );
        case (ps)
            buck_cfg_pkg::PWR_NORMAL: begin
                pick_code = normal_code;
            end
            buck_cfg_pkg::PWR_STANDBY: begin
                pick_code = standby_code;
            end
            buck_cfg_pkg::PWR_SLEEP: begin
                pick_code = sleep_code;
            end
            default: begin
                pick_code = normal_code;
            end
        endcase
    endfunction

    buck_cfg_pkg::bank_state_t state;
    buck_cfg_pkg::bank_state_t next_state;
    logic in_sleep;

    // set-points leave reset matching code zero, so mV never reads 0
    localparam buck_cfg_pkg::bank_state_t STATE_RST = '{
        8'h00, 1'b0, 6'h00, 6'h00, `VBASE_MV, `VBASE_MV,
        1'b0, 1'b0, 1'b0, 1'b0
    };

    assign in_sleep = (power_state == buck_cfg_pkg::PWR_SLEEP);

    always_comb begin
        next_state = state;
        next_state.rd_valid = rd_en;
        // unmapped offsets answer zero
        if (rd_en) begin
            next_state.rd_data = 8'h00;
            for (int i = 0; i < `NUM_REGS; i++) begin
                if (hit[i]) begin
                    next_state.rd_data = reg_value[i];
                end
            end
        end
        next_state.pair_code = pick_code(power_state, pair_normal_code,
            pair_standby_code, pair_sleep_code);
        next_state.third_code = pick_code(power_state, third_normal_code,
            third_standby_code, third_sleep_code);
        next_state.pair_mv = code_to_mv(next_state.pair_code);
        next_state.third_mv = code_to_mv(next_state.third_code);
        // sleep with the state bit clear switches the regulator off
        next_state.pair_on = !in_sleep || pair_sleep_state_bit;
        next_state.third_on = !in_sleep || third_sleep_state_bit;
        next_state.pair_pfm = in_sleep && pair_sleep_state_bit;
        next_state.third_pfm = in_sleep && third_sleep_state_bit;
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state <= STATE_RST;
        end else begin
            state <= next_state;
        end
    end

    assign rd_data = state.rd_data;
    assign rd_valid = state.rd_valid;
    assign pair_active_code = state.pair_code;
    assign pair_setpoint_mv = state.pair_mv;
    assign pair_regulator_on = state.pair_on;
    assign pair_sleep_pfm = state.pair_pfm;
    assign third_active_code = state.third_code;
    assign third_setpoint_mv = state.third_mv;
    assign third_regulator_on = state.third_on;
    assign third_sleep_pfm = state.third_pfm;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_write(logic [7:0] ofs);
        wr_en && addr == ofs;
    endsequence

    sequence s_read(logic [7:0] ofs);
        rd_en && !wr_en && addr == ofs;
    endsequence

    a_pair_standby_write: assert property (
        s_write(`OFS_PAIR_STANDBY) |=>
            pair_standby_code == $past(wdata[`CODE_MSB:0]))
        else $error("pair standby code not stored");

    a_third_sleep_write: assert property (
        s_write(`OFS_THIRD_SLEEP) |=>
            third_sleep_code == $past(wdata[`CODE_MSB:0]))
        else $error("third sleep code not stored");

    a_mode_reset_value: assert property (
        $rose(nrst) |-> pair_mode_field == `RST_MODE_FIELD &&
            third_mode_field == `RST_MODE_FIELD)
        else $error("mode field reset value wrong");

    a_unused_read_zero: assert property (
        s_write(`OFS_PAIR_MODE) ##2 s_read(`OFS_PAIR_MODE) |=>
            (rd_data & ~`MASK_MODE) == 8'h00)
        else $error("unused mode bits read nonzero");

    a_conf_write_read: assert property (
        s_write(`OFS_THIRD_CONF) ##1 !wr_en ##1 s_read(`OFS_THIRD_CONF) |=>
            rd_valid && rd_data == $past(wdata, 3))
        else $error("config readback mismatch");

    a_unmapped_read: assert property (
        rd_en && hit == '0 |=> rd_valid && rd_data == 8'h00)
        else $error("unmapped read not zero");

    a_phase_share: assert property (
        phase_a_freq == phase_b_freq && phase_a_ramp == phase_b_ramp &&
        phase_b_freq == pair_conf_reg[`FREQ_MSB:`FREQ_LSB])
        else $error("phases disagree on shared settings");

    a_setpoint_scale: assert property (
        pair_setpoint_mv == `VBASE_MV + {5'h00, pair_active_code} *
            `VSTEP_MV)
        else $error("pair set-point scale wrong");

    a_sleep_off: assert property (
        in_sleep && !pair_sleep_state_bit |=>
            !pair_regulator_on && !pair_sleep_pfm)
        else $error("pair not off in sleep");

    a_sleep_pfm: assert property (
        in_sleep && third_sleep_state_bit |=>
            third_regulator_on && third_sleep_pfm)
        else $error("third not in pfm in sleep");

    a_sleep_code_pick: assert property (
        in_sleep ##1 in_sleep |-> pair_active_code == $past(pair_sleep_code))
        else $error("sleep code not selected");

    a_ilim_follow: assert property (
        s_write(`OFS_PAIR_CONF) |=>
            pair_current_limit_bit == $past(wdata[`ILIM_BIT]))
        else $error("current limit bit not stored");

endmodule

// [cfg_host_model.sv]
// host side of the byte strobe port of the buck configuration bank;
// assumes one core_clk domain and a bank that answers reads on the
// edge that takes them
`timescale 1ns/1ps

module cfg_host_model (
    // clock
    input wire logic core_clk,
    // request toward the bank
    output logic wr_en,
    output logic rd_en,
    output logic [7:0] addr,
    output logic [7:0] wdata,
    // read answer
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end

    // ****************************************************************
    // access tasks
    // ****************************************************************
    // idle lines show the inverse, so a stale copy is never sampled
    task automatic release_bus();
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = ~addr;
        wdata = ~wdata;
    endtask

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(posedge core_clk);
        #1;
        release_bus();
    endtask

    // answer lands on the edge that takes the strobe, read just after
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output logic ok);
        @(posedge core_clk);
        #1;
        addr = a;
        rd_en = 1'b1;
        @(posedge core_clk);
        #1;
        release_bus();
        ok = rd_valid;
        d = rd_data;
    endtask
endmodule

// [buck_cfg_bank_tb.sv]
// self-checking bench of the buck configuration bank;
// assumes cfg_host_model drives the byte strobe port
`timescale 1ns/1ps
`include "buck_cfg_params.svh"

module buck_cfg_bank_tb;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic wr_en, rd_en, rd_valid;
    logic [7:0] addr, wdata, rd_data;
    buck_cfg_pkg::power_state_t power_state = buck_cfg_pkg::PWR_NORMAL;
    logic [5:0] pnc, psc, pslc, pac, tnc, tsc, tslc, tac;
    logic [3:0] pmf, tmf;
    logic pss, pcl, tss, tcl, pon, ppfm, ton, tpfm;
    logic [1:0] pf, pp, pr, tf, tp, tr, faf, fbf, far_, fbr;
    logic [10:0] pmv, tmv;
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] ofs [10] = '{`OFS_PAIR_NORMAL, `OFS_PAIR_STANDBY,
        `OFS_PAIR_SLEEP, `OFS_PAIR_MODE, `OFS_PAIR_CONF, `OFS_THIRD_NORMAL,
        `OFS_THIRD_STANDBY, `OFS_THIRD_SLEEP, `OFS_THIRD_MODE,
        `OFS_THIRD_CONF};
    logic [7:0] rstv [10] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h08, 8'h00};
    logic [7:0] wmask [10] = '{8'h3F, 8'h3F, 8'h3F, 8'h2F, 8'hFF, 8'h3F,
        8'h3F, 8'h3F, 8'h2F, 8'hFF};
    // the unnamed fourth state code must fall back to normal
    buck_cfg_pkg::power_state_t ps_list [4] = '{buck_cfg_pkg::PWR_NORMAL,
        buck_cfg_pkg::PWR_STANDBY, buck_cfg_pkg::PWR_SLEEP,
        buck_cfg_pkg::power_state_t'(2'h3)};
    logic [5:0] pexp [4] = '{6'h0A, 6'h3F, 6'h00, 6'h0A};
    logic [5:0] texp [4] = '{6'h01, 6'h02, 6'h3E, 6'h01};

    always #50 core_clk = ~core_clk;

    buck_cfg_bank u_buck_cfg_bank (.core_clk(core_clk), .nrst(nrst),
        .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .rd_data(rd_data), .rd_valid(rd_valid), .power_state(power_state),
        .pair_normal_code(pnc), .pair_standby_code(psc),
        .pair_sleep_code(pslc), .pair_mode_field(pmf),
        .pair_sleep_state_bit(pss), .pair_current_limit_bit(pcl),
        .pair_frequency_field(pf), .pair_phase_field(pp),
        .pair_ramp_speed_field(pr), .phase_a_freq(faf), .phase_b_freq(fbf),
        .phase_a_ramp(far_), .phase_b_ramp(fbr), .pair_active_code(pac),
        .pair_setpoint_mv(pmv), .pair_regulator_on(pon),
        .pair_sleep_pfm(ppfm), .third_normal_code(tnc),
        .third_standby_code(tsc), .third_sleep_code(tslc),
        .third_mode_field(tmf), .third_sleep_state_bit(tss),
        .third_current_limit_bit(tcl), .third_frequency_field(tf),
        .third_phase_field(tp), .third_ramp_speed_field(tr),
        .third_active_code(tac), .third_setpoint_mv(tmv),
        .third_regulator_on(ton), .third_sleep_pfm(tpfm));

    cfg_host_model u_cfg_host_model (.core_clk(core_clk), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wdata(wdata), .rd_data(rd_data),
        .rd_valid(rd_valid));

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input logic [10:0] seen, input logic [10:0] exp,
                         input string what);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: %s seen %0h expected %0h", $time,
                     what, seen, exp);
        end
    endtask

    task automatic rd_expect(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        u_cfg_host_model.read_reg(a, d, ok);
        check({10'h000, ok}, 11'h001, "read answer flag");
        check({3'h0, d}, {3'h0, exp}, $sformatf("read of %0h", a));
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_cfg_host_model.write_reg(a, d);
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        for (int i = 0; i < 10; i++) rd_expect(ofs[i], rstv[i]);
        check(11'(pmf), 11'h008, "pair mode reset");
        check(11'(tmf), 11'h008, "third mode reset");
        $display("test reset values done");

        for (int i = 0; i < 10; i++) begin
            wr(ofs[i], 8'hFF);
            rd_expect(ofs[i], wmask[i]);
        end
        check(11'({pss, tss, pcl, tcl}), 11'h00F, "state bits set");
        check(11'(pnc & psc & pslc), 11'h03F, "pair codes");
        check(11'(tnc & tsc & tslc), 11'h03F, "third codes");
        check(11'({pmf, tmf}), 11'h0FF, "mode fields all ones");
        for (int i = 0; i < 10; i++) begin
            wr(ofs[i], 8'h00);
            rd_expect(ofs[i], 8'h00);
        end
        $display("test writable bits done");

        wr(`OFS_PAIR_CONF, 8'hA5);
        wr(`OFS_THIRD_CONF, 8'h5A);
        check(11'({pf, pp, pr, pcl}), 11'h035, "pair fields");
        check(11'({faf, fbf, far_, fbr}), 11'h05A, "phase copies");
        check(11'({tf, tp, tr, tcl}), 11'h04A, "third fields");
        rd_expect(`OFS_THIRD_CONF, 8'h5A);
        $display("test config fields done");

        wr(8'h25, 8'hFF);
        wr(8'h33, 8'hFF);
        rd_expect(8'h25, 8'h00);
        rd_expect(8'h33, 8'h00);
        rd_expect(`OFS_PAIR_CONF, 8'hA5);
        rd_expect(`OFS_THIRD_NORMAL, 8'h00);
        $display("test unmapped offsets done");

        wr(`OFS_PAIR_NORMAL, 8'h0A);
        wr(`OFS_PAIR_STANDBY, 8'h3F);
        wr(`OFS_THIRD_NORMAL, 8'h01);
        wr(`OFS_THIRD_STANDBY, 8'h02);
        wr(`OFS_THIRD_SLEEP, 8'h3E);
        wr(`OFS_PAIR_MODE, 8'h08);
        wr(`OFS_THIRD_MODE, 8'h28);
        for (int s = 0; s < 4; s++) begin
            @(posedge core_clk);
            #1;
            power_state = ps_list[s];
            repeat (2) @(posedge core_clk);
            #1;
            check(11'(pac), 11'(pexp[s]), "pair active code");
            check(11'(tac), 11'(texp[s]), "third active code");
            check(pmv, 11'(300 + 25 * pexp[s]), "pair millivolts");
            check(tmv, 11'(300 + 25 * texp[s]), "third millivolts");
            check(11'({pon, ppfm}), (s == 2) ? 11'h0 : 11'h2, "pair");
            check(11'({ton, tpfm}), (s == 2) ? 11'h3 : 11'h2, "third");
        end
        $display("test power states done");

        @(posedge core_clk);
        #1;
        nrst = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check(11'({pf, pr, tnc}), 11'h000, "fields in reset");
        check(11'(tmf), 11'h008, "third mode in reset");
        nrst = 1'b1;
        rd_expect(`OFS_PAIR_CONF, 8'h00);
        rd_expect(`OFS_PAIR_MODE, 8'h08);
        $display("test second reset done");
        conclude();
    end
endmodule
